/* rtl/mtcs_pkg.sv */
// Operation
// - Lane width selectable 1, 2, 4 or 8
// - Unused lanes carry blank image
// - One lane may serve two chained targets
// - Image size is width times longest lane
// - Identical targets share all lines, load together
// - Master generates data clock for everyone
// - Done drives master select; cascade chains selects
// - Cascade output low after all data sent
// - Handoff within one data clock period
// - Any error halts and reloads whole chain
// - Missing done drives output-enable low
// - Wait bounded data clocks for done
// - Restart when all status lines released
// - No streaming until status lines released
package mtcs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS    = 8;    // System clock period
  localparam int unsigned DCLK_HALF_CYCLES = 5;    // Data clock half period, 80 ns clock
  localparam int unsigned DONE_WAIT_ENH    = 64;   // Done wait, enhanced parts
  localparam int unsigned DONE_WAIT_OLD    = 16;   // Done wait, older parts

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int unsigned LANE_MAX  = 8;           // Widest lane group
  localparam int unsigned DEPTH_DEF = 1024;        // Default words per image
  localparam logic [1:0]  MODE_RST  = 2'h0;        // One lane after reset

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    MTCS_IDLE  = 3'b000,   // Waiting for select and status
    MTCS_SEND  = 3'b001,   // Streaming bits
    MTCS_WAIT  = 3'b010,   // Waiting for done after last bit
    MTCS_FAULT = 3'b011,   // Output-enable held low
    MTCS_CASC  = 3'b100,   // Handed stream to next device
    MTCS_DONE  = 3'b101    // Chain configured
  } mtcs_state_e;

endpackage : mtcs_pkg

/* rtl/mtcs_streamer.sv */
module mtcs_streamer
  import mtcs_pkg::*;
#(
  parameter int unsigned DEPTH      = DEPTH_DEF,  // Words stored per lane group
  parameter bit          ENHANCED   = 1'b1,       // Select 64 or 16 clock done wait
  parameter bit          CASCADE_IN = 1'b0,       // Slave in a cascade
  parameter bit          AUTO_RST   = 1'b1        // Restart after missing-done fault
) (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  // Image memory load port
  input  wire logic                     i_img_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_img_addr,
  input  wire logic [LANE_MAX-1:0]      i_img_data,
  input  wire logic [$clog2(DEPTH):0]   i_img_len,       // Words in image
  input  wire logic [1:0]               i_lane_mode,     // 0:1,1:2,2:4,3:8 lanes
  // Link pins
  input  wire logic                     i_memory_chip_select_n,
  input  wire logic                     i_status_n,
  input  wire logic                     i_dclk,          // Clock from master, slave only
  output logic                          o_dclk,
  output logic [LANE_MAX-1:0]           o_lane_data,     // Bit 0 is serial_lane_zero
  output logic                          o_oe_o,          // Open-drain output-enable, drives 0
  output logic                          o_oe_oe,
  output logic                          o_cascade_select_out_n,
  // Status
  output logic                          o_busy,
  output logic                          o_fault
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [6:0] DONE_WAIT = ENHANCED ? 7'(DONE_WAIT_ENH) : 7'(DONE_WAIT_OLD);

  logic [LANE_MAX-1:0] mem [DEPTH];                 // Image storage
  logic [2:0]          cs_sync_reg;                 // Select synchroniser and history
  logic [2:0]          st_sync_reg;                 // Status synchroniser and history
  logic [2:0]          dk_sync_reg;                 // Link clock synchroniser and history
  mtcs_state_e         state_reg;                   // Sequencer
  logic [3:0]          div_reg;                     // Clock divider
  logic                dclk_reg;                    // Generated data clock
  logic [AW:0]         word_reg;                    // Word pointer
  logic [2:0]          bit_reg;                     // Bit within a word
  logic [6:0]          wait_reg;                    // Done wait counter
  logic [1:0]          mode_reg;                    // Lane mode latched at start
  logic [LANE_MAX-1:0] data_reg;                    // Lane outputs
  logic                fall;                        // Shift moment
  logic                rise;                        // Target sample moment
  logic                done_hi;
  logic                stat_hi;
  logic [3:0]          lanes;                       // Active lane count

  // ****************************************
  // Image memory
  // ****************************************
  // Write port only; the read is in the shift process
  always_ff @(posedge i_clk) begin
    if (i_img_we) begin
      mem[i_img_addr] <= i_img_data;
    end
  end

  // ****************************************
  // Synchronisers
  // ****************************************
  // Pins pass two flops; bit 2 gives edge history
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cs_sync_reg <= 3'h7;
      st_sync_reg <= 3'h0;
      dk_sync_reg <= 3'h0;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], i_memory_chip_select_n};
      st_sync_reg <= {st_sync_reg[1:0], i_status_n};
      dk_sync_reg <= {dk_sync_reg[1:0], i_dclk};
    end
  end

  // Done line is select for master; high done means configured
  assign done_hi = cs_sync_reg[1];
  assign stat_hi = st_sync_reg[1];

  // ****************************************
  // Data clock
  // ****************************************
  // Master divides its own clock; slave follows the master's edges
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg  <= 4'h0;
      dclk_reg <= 1'b0;
    end else if (div_reg == 4'(DCLK_HALF_CYCLES - 1)) begin
      div_reg  <= 4'h0;
      dclk_reg <= ~dclk_reg;
    end else begin
      div_reg  <= div_reg + 4'h1;
    end
  end

  always_comb begin
    if (CASCADE_IN) begin
      fall = dk_sync_reg[2] & ~dk_sync_reg[1];
      rise = ~dk_sync_reg[2] & dk_sync_reg[1];
    end else begin
      fall = dclk_reg & (div_reg == 4'(DCLK_HALF_CYCLES - 1));
      rise = ~dclk_reg & (div_reg == 4'(DCLK_HALF_CYCLES - 1));
    end
  end

  // Lane count from mode
  always_comb begin
    case (mode_reg)
      2'h0:    lanes = 4'h1;
      2'h1:    lanes = 4'h2;
      2'h2:    lanes = 4'h4;
      default: lanes = 4'h8;
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Master select is the done line low; slave select is previous cascade low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= MTCS_IDLE;
      word_reg  <= '0;
      bit_reg   <= 3'h0;
      wait_reg  <= 7'h0;
      mode_reg  <= MODE_RST;
    end else begin
      case (state_reg)
        MTCS_IDLE: begin
          // Hold off until every status line is released
          if (stat_hi && !cs_sync_reg[1] && fall) begin
            state_reg <= MTCS_SEND;
            word_reg  <= '0;
            bit_reg   <= 3'h0;
            mode_reg  <= i_lane_mode;
          end
        end
        MTCS_SEND: begin
          if (!stat_hi) begin
            state_reg <= MTCS_IDLE;
          end else if (fall) begin
            // Narrow modes spend several shifts per stored word
            if (bit_reg + 3'(lanes) == 3'h0 || lanes == 4'h8) begin
              bit_reg  <= 3'h0;
              word_reg <= word_reg + 1'b1;
              if (word_reg + 1'b1 >= i_img_len) begin
                // Slave hands off to the next device; master waits for done
                state_reg <= CASCADE_IN ? MTCS_CASC : MTCS_WAIT;
                wait_reg  <= 7'h0;
              end
            end else begin
              bit_reg <= bit_reg + 3'(lanes);
            end
          end
        end
        MTCS_WAIT: begin
          if (!stat_hi) begin
            state_reg <= MTCS_IDLE;
          end else if (done_hi) begin
            state_reg <= MTCS_DONE;
          end else if (rise) begin
            wait_reg <= wait_reg + 7'h1;
            if (wait_reg + 7'h1 >= DONE_WAIT) begin
              state_reg <= MTCS_FAULT;
            end
          end
        end
        MTCS_FAULT: begin
          // Stay until targets pull status low, then wait for release
          // Without auto restart the chain stays held until reset
          if (!stat_hi && AUTO_RST) begin
            state_reg <= MTCS_IDLE;
          end
        end
        MTCS_CASC: begin
          if (!stat_hi || cs_sync_reg[1]) begin
            state_reg <= MTCS_IDLE;
          end
        end
        MTCS_DONE: begin
          if (!stat_hi) begin
            state_reg <= MTCS_IDLE;
          end
        end
        default: state_reg <= MTCS_IDLE;
      endcase
    end
  end

  // ****************************************
  // Lane shifter
  // ****************************************
  // New bits change on the falling edge so targets sample stable data on rise
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      data_reg <= '0;
    end else if (state_reg == MTCS_SEND) begin
      if (fall) begin
        data_reg <= mem[word_reg[AW-1:0]] >> bit_reg;
      end
    end else if (state_reg == MTCS_WAIT || state_reg == MTCS_CASC) begin
      // Last group must stand a full period, so clear only at the next shift
      if (fall) begin
        data_reg <= '0;
      end
    end else begin
      data_reg <= '0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < LANE_MAX; g++) begin : g_lane
      // Unused lanes stay quiet
      assign o_lane_data[g] = (g < lanes) ? data_reg[g] : 1'b0;
    end
  endgenerate

  assign o_dclk                 = CASCADE_IN ? 1'b0 : dclk_reg;
  assign o_oe_o                 = 1'b0;
  assign o_oe_oe                = (state_reg == MTCS_FAULT);
  // Handoff flag flips within one system clock, far below a data clock
  assign o_cascade_select_out_n = (state_reg != MTCS_CASC);
  assign o_busy                 = (state_reg == MTCS_SEND) || (state_reg == MTCS_WAIT);
  assign o_fault                = (state_reg == MTCS_FAULT);

endmodule : mtcs_streamer

/* testbench/mtcs_streamer_checker.sv */
module mtcs_streamer_checker
  import mtcs_pkg::*;
(
  input wire logic                i_clk,
  input wire logic                i_rst,
  input wire logic                i_memory_chip_select_n,
  input wire logic                i_status_n,
  input wire logic [1:0]          i_lane_mode,
  input wire logic                o_dclk,
  input wire logic [LANE_MAX-1:0] o_lane_data,
  input wire logic                o_oe_o,
  input wire logic                o_oe_oe,
  input wire logic                o_cascade_select_out_n,
  input wire logic                o_busy,
  input wire logic                o_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Five system clocks per data clock phase
  sequence s_hi; o_dclk [*5] ##1 !o_dclk; endsequence
  sequence s_lo; !o_dclk [*5] ##1 o_dclk; endsequence
  AST_DCLK_HI: assert property ($rose(o_dclk) |-> s_hi)
    else $error("data clock high phase wrong");
  AST_DCLK_LO: assert property ($fell(o_dclk) |-> s_lo)
    else $error("data clock low phase wrong");
  AST_UNUSED: assert property ((o_lane_data >> (4'h1 << i_lane_mode)) == 8'h0)
    else $error("unused lane driven");
  AST_STABLE: assert property (o_dclk && $past(o_dclk) && o_busy && $past(o_busy)
    |-> $stable(o_lane_data))
    else $error("lane changed while data clock high");
  AST_ABORT: assert property ($fell(i_status_n) |-> ##[1:4] (!o_busy && o_lane_data == 8'h0))
    else $error("status low did not halt stream");
  AST_OE_FAULT: assert property ($rose(o_fault) |-> o_oe_oe && !o_oe_o)
    else $error("fault without output-enable low");
  AST_NODONE: assert property ($rose(o_fault) |-> !$past(i_memory_chip_select_n, 3))
    else $error("fault although done was high");
  AST_START: assert property ($rose(o_busy)
    |-> $past(i_status_n, 3) && !$past(i_memory_chip_select_n, 3))
    else $error("stream began before release");
  // Cascade output may only drop right after the last group was shifted
  AST_CASC: assert property ($fell(o_cascade_select_out_n) |-> $past(o_busy))
    else $error("cascade select dropped outside handoff");
endmodule : mtcs_streamer_checker

bind mtcs_streamer mtcs_streamer_checker u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_memory_chip_select_n(i_memory_chip_select_n),
  .i_status_n(i_status_n), .i_lane_mode(i_lane_mode), .o_dclk(o_dclk),
  .o_lane_data(o_lane_data), .o_oe_o(o_oe_o), .o_oe_oe(o_oe_oe),
  .o_cascade_select_out_n(o_cascade_select_out_n), .o_busy(o_busy),
  .o_fault(o_fault)
);

/* testbench/mtcs_tgt_model.sv */
module mtcs_tgt_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_dclk,
  input  wire logic        i_sel_n,
  input  wire logic        i_status_n,
  input  wire logic        i_ack,
  input  wire logic        i_err,
  input  wire logic [15:0] i_need,
  output logic             o_done,
  output logic             o_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] rises_reg;  // Data clock rises seen while selected
  logic [7:0]  tmo_reg;    // Reset time-out, shortened
  logic        dclk_reg;
  // Targets share status and done; low status resets them all
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {o_done, o_pull, rises_reg, tmo_reg, dclk_reg} <= '0;
    end else begin
      dclk_reg <= i_dclk;
      if (!i_status_n) begin
        o_done    <= 1'b0;
        rises_reg <= '0;
        o_pull    <= (tmo_reg < 8'd60);
        if (tmo_reg < 8'd60) tmo_reg <= tmo_reg + 8'd1;
      end else begin
        tmo_reg <= '0;
        if (i_err) o_pull <= 1'b1;
        if (i_dclk && !dclk_reg && !i_sel_n) rises_reg <= rises_reg + 16'd1;
        if (i_ack && rises_reg == i_need) o_done <= 1'b1;
      end
    end
  end
endmodule : mtcs_tgt_model

/* testbench/mtcs_streamer_test.sv */
module mtcs_streamer_test
  import mtcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, we, hold, ack, err, lclk, dclk, oe_o, oe_oe, casc_n, busy, fault, done, pull;
  logic slv_sel_n, slv_casc_n, slv_busy, lprev;
  logic [7:0] slv_lanes;
  logic [3:0] addr;
  logic [7:0] wd, lanes;
  logic [4:0] len;
  logic [1:0] mode;
  logic [15:0] need;
  logic [7:0] img [16];
  logic [7:0] eg [128];
  int mismatches, n_checks, ph, ngr, dprev, sph;
  wire sel_n = done | hold;
  wire status_n = !(oe_oe | pull);
  initial begin clk = 0; forever #4 clk = ~clk; end
  initial begin lclk = 0; #13; forever #40 lclk = ~lclk; end
  mtcs_streamer #(.DEPTH(16)) dut (.i_clk(clk), .i_rst(rst), .i_img_we(we), .i_img_addr(addr),
    .i_img_data(wd), .i_img_len(len), .i_lane_mode(mode), .i_memory_chip_select_n(sel_n),
    .i_status_n(status_n), .i_dclk(lclk), .o_dclk(dclk), .o_lane_data(lanes), .o_oe_o(oe_o),
    .o_oe_oe(oe_oe), .o_cascade_select_out_n(casc_n), .o_busy(busy), .o_fault(fault));
  mtcs_tgt_model u_tgt (.i_clk(clk), .i_rst(rst), .i_dclk(dclk), .i_sel_n(sel_n),
    .i_status_n(status_n), .i_ack(ack), .i_err(err), .i_need(need), .o_done(done),
    .o_pull(pull));
  // Slave follows the bench link clock and its own select
  mtcs_streamer #(.DEPTH(16), .CASCADE_IN(1'b1)) u_slv (.i_clk(clk), .i_rst(rst),
    .i_img_we(we), .i_img_addr(addr), .i_img_data(wd), .i_img_len(len), .i_lane_mode(mode),
    .i_memory_chip_select_n(slv_sel_n), .i_status_n(status_n), .i_dclk(lclk), .o_dclk(),
    .o_lane_data(slv_lanes), .o_oe_o(), .o_oe_oe(), .o_cascade_select_out_n(slv_casc_n),
    .o_busy(slv_busy), .o_fault());
  task chk(input logic [7:0] s, input logic [7:0] e, input string m);
    n_checks++;
    if (s !== e) begin mismatches++; $display("[FAIL] %0t %s", $time, m); end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // Bounded wait for busy (s=0), fault (s=1) or slave cascade output (s=2)
  task wfor(input int s, input logic v);
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk);
      if ((s == 2 ? slv_casc_n : (s ? fault : busy)) === v) return;
    end
    mismatches++;
    $display("[FAIL] %0t wait ran out", $time);
    results();
  endtask : wfor
  // Reset, load a random image, work out the lane groups, then select
  task run(input int m, input int n, input logic a);
    int L;
    rst <= 1; hold <= 1; mode <= m[1:0]; len <= n[4:0]; ack <= a;
    slv_sel_n <= 1;
    repeat (20) @(posedge clk);
    rst <= 0;
    L = 1 << m; ngr = n * 8 / L; need = 16'(ngr + 6);
    for (int w = 0; w < n; w++) begin
      @(posedge clk);
      img[w] = 8'($urandom);
      we <= 1; addr <= w[3:0]; wd <= img[w];
      for (int g = 0; g < 8 / L; g++)
        for (int k = 0; k < 8; k++) eg[w * (8 / L) + g][k] = (k < L) ? img[w][g * L + k] : 1'b0;
    end
    @(posedge clk);
    we <= 0; hold <= 0;
  endtask : run
  // Model of the target side: one lane group per data clock rise
  always @(posedge clk) begin
    if (dclk && !dprev) begin
      if (!busy) ph = 0;
      else begin
        if (ph > 0 && ph <= ngr) chk(lanes, eg[ph - 1], "lane bits");
        else if (ph > ngr) chk(lanes, 8'h0, "lane after last group");
        ph++;
      end
    end
    dprev = dclk;
  end
  // Model for the slave, lane bits only with no check after the last group, on rises of the bench link clock
  always @(posedge clk) begin
    if (lclk && !lprev) begin
      if (!slv_busy && slv_casc_n) sph = 0;
      else begin
        if (sph > 0 && sph <= ngr) chk(slv_lanes, eg[sph - 1], "slave lane bits");
        sph++;
      end
    end
    lprev = lclk;
  end
  initial begin
    {rst, hold, we, ack, err} = 5'h18; addr = 0; wd = 0; len = 0; mode = 0; need = 0;
    {mismatches, n_checks, ph, ngr, dprev, sph} = '0;
    slv_sel_n = 1;
    lprev = 0;
    void'($urandom(14779));
    for (int m = 0; m < 4; m++) begin
      run(m, 2 + m * 3, 1);
      wfor(0, 1); wfor(0, 0);
      chk(done, 1, "done not seen");
      chk(fault, 0, "fault on good load");
      chk(casc_n, 1, "master handed off");
      $display("test width %0d done", 1 << m);
    end
    run(2, 4, 1);
    slv_sel_n <= 0;
    wfor(2, 0);
    chk(8'(sph), 8'(ngr), "slave group count");
    repeat (8) @(posedge clk);
    slv_sel_n <= 1;
    repeat (6) @(posedge clk);
    chk(slv_casc_n, 1, "cascade not released");
    $display("test cascade slave done");
    run(3, 16, 0);
    wfor(1, 1);
    chk(oe_oe, 1, "output-enable not low");
    wfor(1, 0); wfor(0, 1);
    chk(status_n, 1, "restart before release");
    $display("test missing done done");
    run(1, 8, 1);
    wfor(0, 1);
    repeat (200) @(posedge clk);
    err <= 1;
    @(posedge clk);
    err <= 0;
    repeat (6) @(posedge clk);
    chk(busy, 0, "stream not halted");
    chk(lanes, 0, "lanes not cleared");
    wfor(0, 1); wfor(0, 0);
    chk(done, 1, "reload failed");
    $display("test error reload done");
    results();
  end
endmodule : mtcs_streamer_test
